/* flash_cfg_pkg.sv */
package flash_cfg_pkg;
   // ------------------------------------------------------------
   // command codes on the data lines
   // ------------------------------------------------------------
   localparam logic [15:0] CMD_CFG_SETUP    = 16'h0060;
   localparam logic [15:0] CMD_CONFIRM_READ = 16'h0003;
   localparam logic [15:0] CMD_CONFIRM_DRV  = 16'h0004;
   localparam logic [15:0] CMD_IDENT_READ   = 16'h0090;
   localparam logic [15:0] CMD_ARRAY_READ   = 16'h00ff;
   localparam logic [15:0] CMD_STATUS_READ  = 16'h0070;
   // ------------------------------------------------------------
   // identifier space offsets, reset values, status value and write masks
   // ------------------------------------------------------------
   localparam logic [7:0]  OFS_READ_CFG   = 8'h05;
   localparam logic [7:0]  OFS_DRIVE_CFG  = 8'h06;
   localparam logic [15:0] RST_READ_CFG   = 16'h8000;
   localparam logic [15:0] RST_DRIVE_CFG  = 16'h0004;
   localparam logic [15:0] STATUS_READY   = 16'h0080;
   localparam logic [15:0] MASK_READ_CFG  = 16'hfd07;
   localparam logic [15:0] MASK_DRIVE_CFG = 16'h0007;
   // ------------------------------------------------------------
   // read_burst_config fields and drive config field
   // ------------------------------------------------------------
   localparam int RB_MODE_BIT = 15;
   localparam int RB_LAT_HI   = 14;
   localparam int RB_LAT_LO   = 11;
   localparam int RB_WPOL_BIT = 10;
   localparam int RB_WDLY_BIT = 8;
   localparam int RB_BLEN_HI  = 2;
   localparam int DRV_HI      = 2;
   // ------------------------------------------------------------
   // host command registers (apb byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_VALUE  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam logic [1:0] OP_WR_READ_CFG  = 2'h0;
   localparam logic [1:0] OP_WR_DRIVE_CFG = 2'h1;
   localparam logic [1:0] OP_RD_READ_CFG  = 2'h2;
   localparam logic [1:0] OP_RD_DRIVE_CFG = 2'h3;
   typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_IDENT} read_mode_e;
endpackage

/* flash_cfg_if.sv */
`timescale 1ns/1ps
interface flash_cfg_if;
   logic        wr_stb;
   logic        rd_stb;
   logic [16:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;
   modport device (input wr_stb, input rd_stb, input addr, input wdata, output rdata, output rvalid);
   modport host   (output wr_stb, output rd_stb, output addr, output wdata, input rdata, input rvalid);
endinterface

/* flash_cfg_device.sv */
`timescale 1ns/1ps
// How it works
// [RULE_01] read config resets to asynchronous mode
// [RULE_02] ident mode offset 5 returns read config
// [RULE_03] bit 15 one asynchronous, zero synchronous
// [RULE_04] bits 14:11 latency code 3 to 13
// [RULE_05] host keeps clock within latency limit
// [RULE_06] bit 10 sets wait active level
// [RULE_07] bit 8 ends wait one cycle early
// [RULE_08] host writes zero to reserved bits; the host passes pwdata[15:0] unmasked, and the device masks them
// [RULE_09] bits 2:0 select burst length code
// [RULE_10] setup 0060h enters status read mode
// [RULE_11] confirm 0003h loads read config, array
// [RULE_12] host shifts value to its wiring
// [RULE_13] host avoids fetching during mode switch
// [RULE_14] drive config resets to 0004h
// [RULE_15] ident mode offset 6 returns drive config
// [RULE_16] drive bits 2:0 set output strength
// [RULE_17] confirm 0004h loads drive config, array
// [RULE_18] drive update ignores program-protect lockout
// [RULE_19] 0090h enters identifier read mode
// [RULE_20] setup pending, confirm code selects register
// [RULE_21] stored codes drive read and output logic
module flash_cfg_device (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   flash_cfg_if.device                    bus,
   input  wire logic                      program_lockout,
   output logic                           async_mode,
   output logic [3:0]                     latency_code,
   output logic                           wait_active_high,
   output logic                           wait_early,
   output logic [2:0]                     burst_length,
   output logic [2:0]                     drive_strength,
   output logic [1:0]                     read_mode
);
   typedef struct packed {
      logic [15:0]                read_cfg;
      logic [15:0]                drive_cfg;
      logic                       setup_pending;
      flash_cfg_pkg::read_mode_e  mode;
      logic [15:0]                rdata;
      logic                       rvalid;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic   unused_lockout;

   assign unused_lockout = program_lockout;

   // ------------------------------------------------------------
   // command decoder
   // ------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      st_d.rvalid = 1'b0;
      if (bus.wr_stb) begin
         if (st_q.setup_pending) begin
            st_d.setup_pending = 1'b0; // RULE_20
            st_d.mode          = flash_cfg_pkg::MODE_ARRAY;
            if (bus.wdata == flash_cfg_pkg::CMD_CONFIRM_READ) begin
               st_d.read_cfg = bus.addr[15:0] & flash_cfg_pkg::MASK_READ_CFG; // RULE_11
            end else if (bus.wdata == flash_cfg_pkg::CMD_CONFIRM_DRV) begin
               // no lockout term gates this load
               st_d.drive_cfg = bus.addr[15:0] & flash_cfg_pkg::MASK_DRIVE_CFG; // RULE_17 RULE_18
            end else begin
               st_d.mode = flash_cfg_pkg::MODE_STATUS;
            end
         end else begin
            case (bus.wdata)
               flash_cfg_pkg::CMD_CFG_SETUP: begin
                  st_d.setup_pending = 1'b1;
                  st_d.mode          = flash_cfg_pkg::MODE_STATUS; // RULE_10
               end
               flash_cfg_pkg::CMD_IDENT_READ: begin
                  st_d.mode = flash_cfg_pkg::MODE_IDENT; // RULE_19
               end
               flash_cfg_pkg::CMD_STATUS_READ: begin
                  st_d.mode = flash_cfg_pkg::MODE_STATUS;
               end
               flash_cfg_pkg::CMD_ARRAY_READ: begin
                  st_d.mode = flash_cfg_pkg::MODE_ARRAY;
               end
               default: begin
               end
            endcase
         end
      end else if (bus.rd_stb) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = 16'h0000;
         case (st_q.mode)
            flash_cfg_pkg::MODE_IDENT: begin
               if (bus.addr[7:0] == flash_cfg_pkg::OFS_READ_CFG) begin
                  st_d.rdata = st_q.read_cfg; // RULE_02
               end else if (bus.addr[7:0] == flash_cfg_pkg::OFS_DRIVE_CFG) begin
                  st_d.rdata = st_q.drive_cfg; // RULE_15
               end
            end
            flash_cfg_pkg::MODE_STATUS: begin
               st_d.rdata = flash_cfg_pkg::STATUS_READY;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q.read_cfg      <= flash_cfg_pkg::RST_READ_CFG; // RULE_01
         st_q.drive_cfg     <= flash_cfg_pkg::RST_DRIVE_CFG; // RULE_14
         st_q.setup_pending <= 1'b0;
         st_q.mode          <= flash_cfg_pkg::MODE_ARRAY;
         st_q.rdata         <= 16'h0000;
         st_q.rvalid        <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // configuration outputs
   // ------------------------------------------------------------
   assign async_mode       = st_q.read_cfg[flash_cfg_pkg::RB_MODE_BIT]; // RULE_03 RULE_21
   assign latency_code     = st_q.read_cfg[flash_cfg_pkg::RB_LAT_HI:flash_cfg_pkg::RB_LAT_LO]; // RULE_04
   assign wait_active_high = st_q.read_cfg[flash_cfg_pkg::RB_WPOL_BIT]; // RULE_06
   assign wait_early       = st_q.read_cfg[flash_cfg_pkg::RB_WDLY_BIT]; // RULE_07
   assign burst_length     = st_q.read_cfg[flash_cfg_pkg::RB_BLEN_HI:0]; // RULE_09
   assign drive_strength   = st_q.drive_cfg[flash_cfg_pkg::DRV_HI:0]; // RULE_16
   assign read_mode        = st_q.mode;
   assign bus.rdata        = st_q.rdata;
   assign bus.rvalid       = st_q.rvalid;
endmodule

/* flash_cfg_host.sv */
`timescale 1ns/1ps
module flash_cfg_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   flash_cfg_if.host        bus
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_CONFIRM, H_IDENT, H_READ, H_WAIT, H_EXIT} host_state_e;
   typedef struct packed {
      host_state_e  fsm;
      logic [1:0]   op;
      logic [15:0]  value;
      logic [15:0]  rdata;
      logic         wr_stb;
      logic         rd_stb;
      logic [16:0]  addr;
      logic [15:0]  wdata;
      logic         pready;
      logic [31:0]  prdata;
      logic         pslverr;
   } host_s;

   host_s st_q;
   host_s st_d;
   logic  busy;
   logic  access;

   assign busy   = (st_q.fsm != H_IDLE);
   assign access = psel && penable && !st_q.pready;

   // ------------------------------------------------------------
   // apb slave and command sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.wr_stb  = 1'b0;
      st_d.rd_stb  = 1'b0;
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      if (access) begin
         st_d.pready = 1'b1;
         st_d.prdata = 32'h0000_0000;
         case (paddr)
            flash_cfg_pkg::REG_CTRL: begin
               if (pwrite && !busy) begin
                  st_d.op  = pwdata[1:0];
                  st_d.fsm = pwdata[1] ? H_IDENT : H_SETUP;
               end
               st_d.prdata = {30'h0, st_q.op};
            end
            flash_cfg_pkg::REG_VALUE: begin
               if (pwrite) begin
                  st_d.value = pwdata[15:0]; // RULE_08 RULE_12
               end
               st_d.prdata = {16'h0, st_q.value};
            end
            flash_cfg_pkg::REG_STATUS: st_d.prdata = {31'h0, busy};
            flash_cfg_pkg::REG_RDATA:  st_d.prdata = {16'h0, st_q.rdata};
            default: st_d.pslverr = 1'b1;
         endcase
      end
      case (st_q.fsm)
         H_IDLE: begin
         end
         H_SETUP: begin
            st_d.wr_stb = 1'b1;
            st_d.addr   = {1'b0, st_q.value};
            st_d.wdata  = flash_cfg_pkg::CMD_CFG_SETUP; // RULE_10
            st_d.fsm    = H_CONFIRM;
         end
         H_CONFIRM: begin
            st_d.wr_stb = 1'b1;
            // confirm follows setup at once, no read in between
            st_d.wdata  = (st_q.op == flash_cfg_pkg::OP_WR_DRIVE_CFG) ? // RULE_13
                          flash_cfg_pkg::CMD_CONFIRM_DRV : flash_cfg_pkg::CMD_CONFIRM_READ; // RULE_11 RULE_17
            st_d.fsm    = H_IDLE;
         end
         H_IDENT: begin
            st_d.wr_stb = 1'b1;
            st_d.addr   = 17'h00000;
            st_d.wdata  = flash_cfg_pkg::CMD_IDENT_READ; // RULE_19
            st_d.fsm    = H_READ;
         end
         H_READ: begin
            st_d.rd_stb = 1'b1;
            st_d.addr   = {9'h000, (st_q.op == flash_cfg_pkg::OP_RD_DRIVE_CFG) ?
                           flash_cfg_pkg::OFS_DRIVE_CFG : flash_cfg_pkg::OFS_READ_CFG};
            st_d.fsm    = H_WAIT;
         end
         H_WAIT: begin
            if (bus.rvalid) begin
               st_d.rdata = bus.rdata;
               st_d.fsm   = H_EXIT;
            end
         end
         H_EXIT: begin
            st_d.wr_stb = 1'b1;
            st_d.wdata  = flash_cfg_pkg::CMD_ARRAY_READ;
            st_d.fsm    = H_IDLE;
         end
         default: st_d.fsm = H_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{fsm: H_IDLE, op: 2'h0, value: 16'h0000, rdata: 16'h0000, wr_stb: 1'b0, rd_stb: 1'b0,
                   addr: 17'h00000, wdata: 16'h0000, pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata     = st_q.prdata;
   assign pready     = st_q.pready;
   assign pslverr    = st_q.pslverr;
   assign bus.wr_stb = st_q.wr_stb;
   assign bus.rd_stb = st_q.rd_stb;
   assign bus.addr   = st_q.addr;
   assign bus.wdata  = st_q.wdata;
endmodule

/* flash_cfg_asserts.sv */
`timescale 1ns/1ps
module flash_cfg_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [16:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        rvalid
);
   logic        setup_q;
   logic [15:0] rd_cfg_q;
   logic [15:0] drv_cfg_q;
   // ----------------------------------------
   // shadow copies of both configuration words
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_q   <= 1'b0;
         rd_cfg_q  <= flash_cfg_pkg::RST_READ_CFG;
         drv_cfg_q <= flash_cfg_pkg::RST_DRIVE_CFG;
      end else begin
         setup_q <= wr_stb && wdata == flash_cfg_pkg::CMD_CFG_SETUP;
         if (setup_q && wr_stb && wdata == flash_cfg_pkg::CMD_CONFIRM_READ) begin
            rd_cfg_q <= addr[15:0] & flash_cfg_pkg::MASK_READ_CFG;
         end
         if (setup_q && wr_stb && wdata == flash_cfg_pkg::CMD_CONFIRM_DRV) begin
            drv_cfg_q <= addr[15:0] & flash_cfg_pkg::MASK_DRIVE_CFG;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      wr_stb && wdata == flash_cfg_pkg::CMD_CFG_SETUP;
   endsequence
   sequence s_ident_rd(logic [7:0] ofs);
      wr_stb && wdata == flash_cfg_pkg::CMD_IDENT_READ ##1 rd_stb && addr[7:0] == ofs;
   endsequence
   AST_RD_ANSWER: assert property (rd_stb |=> rvalid) else $error("no answer after read");
   AST_NO_SPURIOUS: assert property (rvalid |-> $past(rd_stb)) else $error("answer without read");
   AST_RDATA_HOLD: assert property (!rd_stb |=> $stable(rdata)) else $error("read data moved");
   AST_CONFIRM:
      assert property (s_setup |=> wr_stb && wdata inside {16'h0003, 16'h0004} && $stable(addr))
      else $error("setup not confirmed with same value");
   AST_RD_CFG_VAL:
      assert property (s_ident_rd(flash_cfg_pkg::OFS_READ_CFG) |=> rdata == rd_cfg_q)
      else $error("read config value wrong");
   AST_DRV_CFG_VAL:
      assert property (s_ident_rd(flash_cfg_pkg::OFS_DRIVE_CFG) |=> rdata == drv_cfg_q)
      else $error("drive config value wrong");
   AST_IDENT_FIRST:
      assert property (rd_stb |-> $past(wr_stb && wdata == flash_cfg_pkg::CMD_IDENT_READ))
      else $error("read outside ident mode");
   AST_BACK_TO_ARRAY:
      assert property (rvalid |-> ##2 wr_stb && wdata == flash_cfg_pkg::CMD_ARRAY_READ)
      else $error("array mode not restored");
endmodule

/* tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch at %0t got %h expected %h", $time, a, b); end end
module tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, program_lockout = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic        e, async_mode, wait_active_high, wait_early;
   logic [3:0]  latency_code;
   logic [2:0]  burst_length, drive_strength;
   logic [1:0]  read_mode;
   int          n_fail = 0, total_checks = 0, cycles = 0;
   flash_cfg_if link ();
   flash_cfg_host flash_cfg_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus(link));
   flash_cfg_device flash_cfg_device_i (.pclk(pclk), .presetn(presetn), .bus(link),
      .program_lockout(program_lockout), .async_mode(async_mode), .latency_code(latency_code),
      .wait_active_high(wait_active_high), .wait_early(wait_early), .burst_length(burst_length),
      .drive_strength(drive_strength), .read_mode(read_mode));
   flash_cfg_asserts flash_cfg_asserts_i (.pclk(pclk), .presetn(presetn), .wr_stb(link.wr_stb),
      .rd_stb(link.rd_stb), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
   initial begin
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // one controller order, waiting for busy to clear
   task automatic op(input logic [1:0] code, input logic [15:0] v);
      apb(1'b1, flash_cfg_pkg::REG_VALUE, {16'h0000, v});
      apb(1'b1, flash_cfg_pkg::REG_CTRL, {30'h0, code});
      do apb(1'b0, flash_cfg_pkg::REG_STATUS, 32'h0); while (r[0] !== 1'b0);
      if (code[1]) apb(1'b0, flash_cfg_pkg::REG_RDATA, 32'h0);
   endtask
   task automatic t_reset();
      op(flash_cfg_pkg::OP_RD_READ_CFG, 16'h0);
      `CHK(r[15:0], 16'h8000)
      op(flash_cfg_pkg::OP_RD_DRIVE_CFG, 16'h0);
      `CHK(r[15:0], 16'h0004)
      `CHK(drive_strength, 3'h4)
      $display("reset test done");
   endtask
   task automatic t_read_cfg();
      // latency codes legal at 50 MHz, reserved bits zero
      logic [15:0] vals [6] = '{16'h2902, 16'h6d03, 16'h6907, 16'h3407, 16'hb002, 16'hc507};
      foreach (vals[i]) begin
         op(flash_cfg_pkg::OP_WR_READ_CFG, vals[i]);
         `CHK(read_mode, 2'h0)
         `CHK({async_mode, latency_code, wait_active_high, wait_early, burst_length},
              {vals[i][15:10], vals[i][8], vals[i][2:0]})
         op(flash_cfg_pkg::OP_RD_READ_CFG, 16'h0);
         `CHK(r[15:0], vals[i] & 16'hfd07)
      end
      $display("read config test done");
   endtask
   task automatic t_drive_cfg();
      program_lockout <= 1'b1;
      for (int c = 1; c <= 6; c++) begin
         op(flash_cfg_pkg::OP_WR_DRIVE_CFG, 16'(c));
         `CHK(drive_strength, 3'(c))
         op(flash_cfg_pkg::OP_RD_DRIVE_CFG, 16'h0);
         `CHK(r[15:0], 16'(c))
      end
      op(flash_cfg_pkg::OP_RD_READ_CFG, 16'h0);
      `CHK(r[15:0], 16'hc507)
      program_lockout <= 1'b0;
      $display("drive config test done");
   endtask
   task automatic t_unmapped();
      apb(1'b1, 8'h10, 32'h0000_0001);
      `CHK(e, 1'b1)
      op(flash_cfg_pkg::OP_RD_DRIVE_CFG, 16'h0);
      `CHK(r[15:0], 16'h0006)
      $display("unmapped test done");
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_read_cfg();
      t_drive_cfg();
      t_unmapped();
      tally_and_finish();
   end
endmodule
